// >>> hdl/tsw_serial_io.sv
`timescale 1ns/1ps
// Functional notes
// - highway receive lines are sampled and written to downstream memory.
// - upstream memory bytes are shifted out on highway transmit lines.
// - slots flagged in tristate memory leave their highway line undriven.
// - highway output enable cleared releases every highway transmit line.
// - driver gate is low exactly while its transmit line carries data.
// - driver gates stay high during reset.
// - IOM subscriber frame sync is input or output by configuration.
// - burst mode drives subscriber frame sync as link direction.
// - subscriber clock is input or output in IOM, output in burst.
// - subscriber clock double rate only in IOM, single in burst.
// - IOM up lines are inputs feeding the upstream path.
// - IOM down lines are outputs carrying downstream slots.
// - burst mode makes all eight lines bidirectional ports.
// - drive style selects push-pull or open drain on subscriber lines.
// - unassigned channels and cleared subscriber enable leave lines undriven.
module tsw_serial_io
    import tsw_pkg::*;
(
    // system clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // configuration
    input wire logic highway_out_enable_i,
    input wire logic hwy_double_rate_i,
    input wire logic subscriber_out_enable_i,
    input wire logic subscriber_drive_style_i,
    input wire logic burst_direction_mode_i,
    input wire logic sub_frame_master_i,
    input wire logic sub_clock_master_i,
    input wire logic sub_double_rate_i,
    // highway pins
    input wire logic highway_bit_clock_i,
    input wire logic highway_frame_sync_i,
    input wire logic [3:0] highway_rx_line_i,
    output logic [3:0] highway_tx_line_o,
    output logic [3:0] highway_tx_oe_o,
    output logic [3:0] highway_driver_gate_n_o,
    // highway memory side
    output logic hwy_dn_wr_o,
    output tsw_slot_t hwy_dn_slot_o,
    output logic [31:0] hwy_dn_data_o,
    output tsw_slot_t hwy_up_slot_o,
    input wire logic [31:0] hwy_up_data_i,
    input wire logic [3:0] hwy_tristate_flag_i,
    // subscriber pins
    input wire logic subscriber_frame_sync_i,
    output logic subscriber_frame_sync_o,
    output logic subscriber_frame_sync_oe_o,
    input wire logic subscriber_bit_clock_i,
    output logic subscriber_bit_clock_o,
    output logic subscriber_bit_clock_oe_o,
    input wire logic [3:0] subscriber_up_line_i,
    output logic [3:0] subscriber_up_line_o,
    output logic [3:0] subscriber_up_line_oe_o,
    input wire logic [3:0] subscriber_down_line_i,
    output logic [3:0] subscriber_down_line_o,
    output logic [3:0] subscriber_down_line_oe_o,
    // subscriber memory side
    output logic sub_up_wr_o,
    output tsw_slot_t sub_up_slot_o,
    output logic [63:0] sub_up_data_o,
    output tsw_slot_t sub_dn_slot_o,
    input wire logic [63:0] sub_dn_data_i,
    input wire logic [7:0] sub_assigned_i
);
    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d);
        shift_in = {b[6:0], d};
    endfunction

    function automatic logic drive_oe(input logic d, input logic en, input logic od);
        drive_oe = en & (~od | ~d);
    endfunction

    // highway link domain
    logic [1:0] hcfg_s2;
    logic hwy_ph;
    tsw_cnt_t hwy_cnt;
    logic hwy_step;
    logic hwy_last;
    logic [7:0] hwy_rx_sh [4];
    logic [31:0] hwy_rx_word;
    tsw_slot_t hwy_rx_slot;
    logic hwy_rx_tog;
    logic [7:0] hwy_tx_sh [4];
    logic [3:0] hwy_tx_vld;
    logic hwy_req_tog;
    tsw_slot_t hwy_req_slot;
    logic hwy_ack_lvl;
    logic hwy_ok;
    // system domain side of the highway
    logic [31:0] hold_data;
    logic [3:0] hold_flag;
    logic ack_tog;
    logic rd_pend;
    logic req_pulse;
    logic rx_pulse;

    // configuration into the highway clock
    tsw_sync3 #(
        .W(2)
    ) u_hcfg_sync (
        .clk_i(highway_bit_clock_i),
        .rstn_i(rstn_i),
        .d_i({hwy_double_rate_i, highway_out_enable_i}),
        .q_o(hcfg_s2)
    );

    // frame and bit position, double rate takes two clocks per bit
    assign hwy_step = (~hcfg_s2[1] | hwy_ph) & ~highway_frame_sync_i;
    assign hwy_last = hwy_step & (hwy_cnt[2:0] == `TSW_LAST_BIT);
    assign hwy_ok = (hwy_ack_lvl == hwy_req_tog);

    always_ff @(posedge highway_bit_clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hwy_ph <= 1'b0;
            hwy_cnt <= '0;
        end
        else if (highway_frame_sync_i)
        begin
            hwy_ph <= 1'b0;
            hwy_cnt <= '0;
        end
        else
        begin
            hwy_ph <= hcfg_s2[1] & ~hwy_ph;
            if (hwy_step)
                hwy_cnt <= hwy_cnt + 1'b1;
        end
    end

    // receive shift, byte handed over per slot
    always_ff @(posedge highway_bit_clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int l = 0; l < 4; l++)
                hwy_rx_sh[l] <= 8'h00;
            hwy_rx_word <= 32'h0;
            hwy_rx_slot <= '0;
            hwy_rx_tog <= 1'b0;
        end
        else if (hwy_step)
        begin
            for (int l = 0; l < 4; l++)
            begin
                hwy_rx_sh[l] <= shift_in(hwy_rx_sh[l], highway_rx_line_i[l]);
                if (hwy_last)
                    hwy_rx_word[l*8+:8] <= shift_in(hwy_rx_sh[l], highway_rx_line_i[l]);
            end
            if (hwy_last)
            begin
                hwy_rx_slot <= hwy_cnt[7:3];
                hwy_rx_tog <= ~hwy_rx_tog;
            end
        end
    end

    // transmit shift, request two slots ahead
    always_ff @(posedge highway_bit_clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int l = 0; l < 4; l++)
                hwy_tx_sh[l] <= 8'h00;
            hwy_tx_vld <= 4'h0;
            hwy_req_tog <= 1'b0;
            hwy_req_slot <= '0;
        end
        else if (hwy_last)
        begin
            for (int l = 0; l < 4; l++)
            begin
                hwy_tx_sh[l] <= hwy_ok ? hold_data[l*8+:8] : 8'h00;
                hwy_tx_vld[l] <= hwy_ok & ~hold_flag[l];
            end
            hwy_req_tog <= ~hwy_req_tog;
            hwy_req_slot <= hwy_cnt[7:3] + `TSW_SLOT_AHEAD;
        end
        else if (hwy_step)
            for (int l = 0; l < 4; l++)
                hwy_tx_sh[l] <= {hwy_tx_sh[l][6:0], 1'b0};
    end

    // line enable and driver gate from one value, same edge
    always_ff @(posedge highway_bit_clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            highway_tx_oe_o <= 4'h0;
            highway_driver_gate_n_o <= 4'hf;
        end
        else
            for (int l = 0; l < 4; l++)
            begin
                if (hwy_last)
                begin
                    highway_tx_oe_o[l] <= hcfg_s2[0] & hwy_ok & ~hold_flag[l];
                    highway_driver_gate_n_o[l] <= ~(hcfg_s2[0] & hwy_ok & ~hold_flag[l]);
                end
                else
                begin
                    highway_tx_oe_o[l] <= hcfg_s2[0] & hwy_tx_vld[l];
                    highway_driver_gate_n_o[l] <= ~(hcfg_s2[0] & hwy_tx_vld[l]);
                end
            end
    end

    always_comb
    begin
        for (int l = 0; l < 4; l++)
            highway_tx_line_o[l] = hwy_tx_sh[l][7];
    end

    tsw_toggle_sync u_ack_sync (
        .clk_i(highway_bit_clock_i),
        .rstn_i(rstn_i),
        .tog_i(ack_tog),
        .level_o(hwy_ack_lvl),
        .pulse_o()
    );

    tsw_toggle_sync u_req_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tog_i(hwy_req_tog),
        .level_o(),
        .pulse_o(req_pulse)
    );

    tsw_toggle_sync u_rx_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tog_i(hwy_rx_tog),
        .level_o(),
        .pulse_o(rx_pulse)
    );

    // upstream read and downstream write in the system domain
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hwy_up_slot_o <= '0;
            rd_pend <= 1'b0;
            hold_data <= 32'h0;
            hold_flag <= `TSW_FLAG_RST;
            ack_tog <= 1'b0;
        end
        else if (req_pulse)
        begin
            hwy_up_slot_o <= hwy_req_slot;
            rd_pend <= 1'b1;
        end
        else if (rd_pend)
        begin
            hold_data <= hwy_up_data_i;
            hold_flag <= hwy_tristate_flag_i;
            ack_tog <= ~ack_tog;
            rd_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hwy_dn_wr_o <= 1'b0;
            hwy_dn_slot_o <= '0;
            hwy_dn_data_o <= 32'h0;
        end
        else
        begin
            hwy_dn_wr_o <= rx_pulse;
            if (rx_pulse)
            begin
                hwy_dn_slot_o <= hwy_rx_slot;
                hwy_dn_data_o <= hwy_rx_word;
            end
        end
    end

    // subscriber side, system domain
    logic [9:0] sub_pins;
    tsw_sub_mode_e sub_mode;
    logic clk_master;
    logic fs_master;
    logic sub_dbl;
    logic [3:0] div_cnt;
    logic gen_clk;
    logic sub_lvl;
    logic sub_prev;
    logic sub_rise;
    logic sub_ph;
    logic sub_step;
    logic fs_prev;
    logic fs_pend;
    logic sub_restart;
    logic sub_last;
    tsw_cnt_t sub_cnt;
    logic sub_dir;
    logic next_dir;
    logic [7:0] lane_in;
    logic [7:0] rx_en;
    logic [7:0] sub_rx_sh [8];
    logic [7:0] sub_tx_sh [8];
    logic [7:0] next_tx_sh [8];
    logic [7:0] sub_vld;
    logic [7:0] next_vld;
    logic [7:0] lane_oe;
    logic [7:0] lane_out;

    tsw_sync3 #(
        .W(10)
    ) u_sub_pins (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({subscriber_bit_clock_i, subscriber_frame_sync_i,
              subscriber_up_line_i, subscriber_down_line_i}),
        .q_o(sub_pins)
    );

    assign sub_mode = burst_direction_mode_i ? TSW_MODE_BURST : TSW_MODE_IOM;
    assign clk_master = (sub_mode == TSW_MODE_BURST) | sub_clock_master_i;
    assign fs_master = (sub_mode == TSW_MODE_BURST) | sub_frame_master_i;
    assign sub_dbl = sub_double_rate_i & (sub_mode == TSW_MODE_IOM);
    assign sub_lvl = clk_master ? gen_clk : sub_pins[9];
    assign sub_rise = sub_lvl & ~sub_prev;
    assign sub_step = sub_rise & (~sub_dbl | sub_ph);
    assign sub_restart = ~fs_master & fs_pend;
    assign sub_last = sub_step & ~sub_restart & (sub_cnt[2:0] == `TSW_LAST_BIT);
    assign sub_dir = (sub_cnt[7:3] < `TSW_BURST_TX_SLOTS);
    assign next_dir = (tsw_slot_t'(sub_cnt[7:3] + 1'b1) < `TSW_BURST_TX_SLOTS);
    assign lane_in = sub_pins[7:0];

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_cnt <= 4'h0;
            gen_clk <= 1'b0;
        end
        else if (div_cnt == `TSW_SUB_HALF - 4'h1)
        begin
            div_cnt <= 4'h0;
            gen_clk <= ~gen_clk;
        end
        else
            div_cnt <= div_cnt + 4'h1;
    end

    // bit and frame position; a frame sync edge that meets a step still restarts
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sub_prev <= 1'b0;
            sub_ph <= 1'b0;
            fs_prev <= 1'b0;
            fs_pend <= 1'b0;
            sub_cnt <= '0;
        end
        else
        begin
            sub_prev <= sub_lvl;
            fs_prev <= sub_pins[8];
            if (sub_rise)
                sub_ph <= sub_dbl & ~sub_ph;
            if (sub_pins[8] & ~fs_prev)
                fs_pend <= 1'b1;
            else if (sub_step)
                fs_pend <= 1'b0;
            if (sub_step)
                sub_cnt <= sub_restart ? '0 : sub_cnt + 1'b1;
        end
    end

    // receive lanes: up lines in IOM, all lanes in the burst receive half
    always_comb
    begin
        for (int l = 0; l < 8; l++)
            rx_en[l] = (sub_mode == TSW_MODE_BURST) ? ~sub_dir : (l >= `TSW_SUB_UP_FIRST);
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int l = 0; l < 8; l++)
                sub_rx_sh[l] <= 8'h00;
            sub_up_wr_o <= 1'b0;
            sub_up_slot_o <= '0;
            sub_up_data_o <= 64'h0;
        end
        else
        begin
            sub_up_wr_o <= sub_last & (|rx_en);
            if (sub_step)
                for (int l = 0; l < 8; l++)
                begin
                    sub_rx_sh[l] <= shift_in(sub_rx_sh[l], lane_in[l]);
                    if (sub_last)
                        sub_up_data_o[l*8+:8] <= rx_en[l] ? shift_in(sub_rx_sh[l], lane_in[l])
                                                          : 8'h00;
                end
            if (sub_last)
                sub_up_slot_o <= sub_cnt[7:3];
        end
    end

    // transmit lanes: down lines in IOM, all lanes in the burst send half
    always_comb
    begin
        for (int l = 0; l < 8; l++)
        begin
            next_tx_sh[l] = sub_tx_sh[l];
            next_vld[l] = sub_vld[l];
            if (sub_last)
            begin
                next_tx_sh[l] = sub_dn_data_i[l*8+:8];
                next_vld[l] = sub_assigned_i[l] &
                              ((sub_mode == TSW_MODE_BURST) ? next_dir
                                                            : (l < `TSW_SUB_UP_FIRST));
            end
            else if (sub_step)
                next_tx_sh[l] = {sub_tx_sh[l][6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int l = 0; l < 8; l++)
                sub_tx_sh[l] <= 8'h00;
            sub_vld <= 8'h00;
            lane_oe <= 8'h00;
            sub_dn_slot_o <= '0;
        end
        else
        begin
            for (int l = 0; l < 8; l++)
            begin
                sub_tx_sh[l] <= next_tx_sh[l];
                lane_oe[l] <= drive_oe(next_tx_sh[l][7],
                                       subscriber_out_enable_i & next_vld[l]
                                       & ((sub_mode == TSW_MODE_BURST)
                                          | (l < `TSW_SUB_UP_FIRST)),
                                       subscriber_drive_style_i);
            end
            sub_vld <= next_vld;
            if (sub_last)
                sub_dn_slot_o <= sub_cnt[7:3] + `TSW_SLOT_AHEAD;
        end
    end

    always_comb
    begin
        for (int l = 0; l < 8; l++)
            lane_out[l] = sub_tx_sh[l][7];
    end

    assign subscriber_down_line_o = lane_out[3:0];
    assign subscriber_down_line_oe_o = lane_oe[3:0];
    assign subscriber_up_line_o = lane_out[7:4];
    assign subscriber_up_line_oe_o = lane_oe[7:4];
    assign subscriber_bit_clock_o = gen_clk;

    // frame sync and clock pin direction
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            subscriber_frame_sync_o <= 1'b0;
            subscriber_frame_sync_oe_o <= 1'b0;
            subscriber_bit_clock_oe_o <= 1'b0;
        end
        else
        begin
            subscriber_frame_sync_o <= (sub_mode == TSW_MODE_BURST) ? sub_dir
                                                                    : (sub_cnt == '0);
            subscriber_frame_sync_oe_o <= fs_master;
            subscriber_bit_clock_oe_o <= clk_master;
        end
    end

    // checks
    sequence s_slot_loaded;
        hwy_last && hwy_ok;
    endsequence

    property p_gate_tracks_oe;
        @(posedge highway_bit_clock_i) disable iff (!rstn_i)
        highway_driver_gate_n_o == ~highway_tx_oe_o;
    endproperty
    a_gate_tracks_oe: assert property (p_gate_tracks_oe) else $error("gate and enable differ");

    property p_hwy_disabled;
        @(posedge highway_bit_clock_i) disable iff (!rstn_i)
        !hcfg_s2[0] |=> highway_tx_oe_o == 4'h0 && highway_driver_gate_n_o == 4'hf;
    endproperty
    a_hwy_disabled: assert property (p_hwy_disabled) else $error("highway driven while off");

    property p_flag_releases;
        @(posedge highway_bit_clock_i) disable iff (!rstn_i)
        s_slot_loaded ##0 hold_flag[0] |=> !highway_tx_oe_o[0] && highway_driver_gate_n_o[0];
    endproperty
    a_flag_releases: assert property (p_flag_releases) else $error("flagged slot driven");

    property p_tx_data;
        @(posedge highway_bit_clock_i) disable iff (!rstn_i)
        s_slot_loaded |=> highway_tx_line_o[0] == $past(hold_data[7]);
    endproperty
    a_tx_data: assert property (p_tx_data) else $error("wrong first tx bit");

    property p_rx_write;
        @(posedge clk_i) disable iff (!rstn_i)
        rx_pulse |=> hwy_dn_wr_o && hwy_dn_data_o == $past(hwy_rx_word);
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("received byte not written");

    property p_sub_disabled;
        @(posedge clk_i) disable iff (!rstn_i)
        !subscriber_out_enable_i |=> subscriber_up_line_oe_o == 4'h0
                                     && subscriber_down_line_oe_o == 4'h0;
    endproperty
    a_sub_disabled: assert property (p_sub_disabled) else $error("subscriber driven while off");

    property p_open_drain;
        @(posedge clk_i) disable iff (!rstn_i)
        subscriber_drive_style_i ##1 subscriber_drive_style_i |-> (lane_oe & lane_out) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

    property p_iom_up_inputs;
        @(posedge clk_i) disable iff (!rstn_i)
        (sub_mode == TSW_MODE_IOM)[*2] |-> subscriber_up_line_oe_o == 4'h0;
    endproperty
    a_iom_up_inputs: assert property (p_iom_up_inputs) else $error("up line driven in IOM");

    property p_burst_dir;
        @(posedge clk_i) disable iff (!rstn_i)
        sub_mode == TSW_MODE_BURST |=> subscriber_frame_sync_oe_o
                                       && subscriber_frame_sync_o == $past(sub_dir);
    endproperty
    a_burst_dir: assert property (p_burst_dir) else $error("direction pin wrong");

    property p_burst_single;
        @(posedge clk_i) disable iff (!rstn_i)
        sub_mode == TSW_MODE_BURST && sub_rise |-> sub_step;
    endproperty
    a_burst_single: assert property (p_burst_single) else $error("burst clock not single rate");
endmodule

// >>> hdl/tsw_defs.svh
`ifndef TSW_DEFS_SVH
`define TSW_DEFS_SVH

// frame layout shared by both serial sides
`define TSW_SLOTS 32
`define TSW_SLOT_W 5
`define TSW_BITS 8
`define TSW_CNT_W 8
`define TSW_LAST_BIT 3'h7
`define TSW_SLOT_AHEAD 5'h02
// highway side
`define TSW_HWY_LANES 4
// subscriber side: lanes 0..3 down lines, 4..7 up lines
`define TSW_SUB_LANES 8
`define TSW_SUB_UP_FIRST 4
`define TSW_BURST_TX_SLOTS 5'h10
// generated subscriber clock: half period in clk_i cycles
`define TSW_SUB_HALF 4'h4
// highway tristate flags after reset: all lines released
`define TSW_FLAG_RST 4'hf

`endif

// >>> hdl/tsw_pkg.sv
package tsw_pkg;
    `include "tsw_defs.svh"

    typedef logic [`TSW_SLOT_W-1:0] tsw_slot_t;
    typedef logic [`TSW_CNT_W-1:0] tsw_cnt_t;

    typedef enum logic {
        TSW_MODE_IOM,
        TSW_MODE_BURST
    } tsw_sub_mode_e;
endpackage

// >>> hdl/tsw_sync3.sv
`timescale 1ns/1ps
// pin sampler: three stages, change taken once stages two and three agree
module tsw_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            q_o <= '0;
        else
            for (int i = 0; i < W; i++)
                if (s2[i] == s3[i])
                    q_o[i] <= s3[i];
    end
endmodule

// >>> hdl/tsw_toggle_sync.sv
`timescale 1ns/1ps
// toggle crossing: synchronised level and one-cycle pulse per toggle
module tsw_toggle_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // toggle in, event out
    input wire logic tog_i,
    output logic level_o,
    output logic pulse_o
);
    logic s1;
    logic s2;
    logic s3;
    logic s4;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            s4 <= 1'b0;
        end
        else
        begin
            s1 <= tog_i;
            s2 <= s1;
            s3 <= s2;
            s4 <= s3;
        end
    end

    // a toggle counts once it reaches stage three; pulse while stages three and four differ
    assign level_o = s3;
    assign pulse_o = s3 ^ s4;
endmodule

// >>> tb/tsw_hwy_far.sv
`timescale 1ns/1ps
module tsw_hwy_far (
    // highway pins
    output logic bclk_o,
    output logic fs_o,
    output logic [3:0] rx_o,
    input wire logic [3:0] tx_i,
    // lane 0 byte seen in slot 5
    output logic [7:0] tx_byte_o
);
    int n = 300;
    logic [7:0] b;
    initial
    begin
        bclk_o = 1'b0;
        fs_o = 1'b0;
        rx_o = 4'h0;
        tx_byte_o = 8'h00;
        #3;
        forever #24 bclk_o = ~bclk_o;
    end
    always @(posedge bclk_o)
    begin
        if (n / 8 == 5)
            tx_byte_o <= {tx_byte_o[6:0], tx_i[0]};
        n <= (n >= 255) ? -1 : n + 1;
    end
    // one sync cycle then 256 steps, msb first
    always @(negedge bclk_o)
    begin
        fs_o <= (n == -1);
        for (int l = 0; l < 4; l++)
        begin
            b = {2'(l), 1'b1, 5'(n / 8)};
            rx_o[l] <= (n < 0) ? 1'b0 : b[7 - n % 8];
        end
    end
endmodule

// >>> tb/tdm_switch_serial_port_io_tb.sv
`timescale 1ns/1ps
module tdm_switch_serial_port_io_tb
    import tsw_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b1;
    logic hen = 1'b1, sen = 1'b1, od = 1'b0, bm = 1'b0, fm = 1'b1;
    logic [3:0] flg = 4'h0;
    logic [63:0] sdn = 64'h0;
    logic cm = 1'b1;
    logic [3:0] upl = 4'hf, dl, s_dl;
    logic [7:0] asg = 8'hff;
    logic bclk, fs, hwr, swr, fso, fsoe, dcoe;
    logic [3:0] rx, tx, hoe, gate, uoe, doe;
    logic [3:0] s_hoe, s_uoe, s_doe;
    logic s_fso, s_fsoe, s_dcoe;
    tsw_slot_t hslot, uslot;
    logic [31:0] hdn, got_dn = 32'h0;
    logic [63:0] sup, got_up = 64'h0;
    logic [7:0] tbyte;
    int failures = 0;
    int n_checks = 0;
    always #5 clk_i = ~clk_i;
    tsw_hwy_far far_u (.bclk_o(bclk), .fs_o(fs), .rx_o(rx), .tx_i(tx), .tx_byte_o(tbyte));
    tsw_serial_io dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .highway_out_enable_i(hen), .hwy_double_rate_i(1'b0),
        .subscriber_out_enable_i(sen), .subscriber_drive_style_i(od),
        .burst_direction_mode_i(bm), .sub_frame_master_i(fm),
        .sub_clock_master_i(cm), .sub_double_rate_i(1'b0),
        .highway_bit_clock_i(bclk), .highway_frame_sync_i(fs),
        .highway_rx_line_i(rx), .highway_tx_line_o(tx),
        .highway_tx_oe_o(hoe), .highway_driver_gate_n_o(gate),
        .hwy_dn_wr_o(hwr), .hwy_dn_slot_o(hslot), .hwy_dn_data_o(hdn),
        .hwy_up_slot_o(uslot), .hwy_up_data_i({4{3'h5, uslot}}),
        .hwy_tristate_flag_i(flg),
        .subscriber_frame_sync_i(1'b0), .subscriber_frame_sync_o(fso),
        .subscriber_frame_sync_oe_o(fsoe), .subscriber_bit_clock_i(1'b0),
        .subscriber_bit_clock_o(), .subscriber_bit_clock_oe_o(dcoe),
        .subscriber_up_line_i(upl), .subscriber_up_line_o(),
        .subscriber_up_line_oe_o(uoe), .subscriber_down_line_i(4'h0),
        .subscriber_down_line_o(dl), .subscriber_down_line_oe_o(doe),
        .sub_up_wr_o(swr), .sub_up_slot_o(), .sub_up_data_o(sup),
        .sub_dn_slot_o(), .sub_dn_data_i(sdn), .sub_assigned_i(asg)
    );
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // run and collect what the pins showed
    task automatic run(input int cyc);
        {s_hoe, s_uoe, s_doe, s_fso, s_fsoe, s_dcoe, s_dl} = '0;
        repeat (cyc)
        begin
            @(posedge clk_i);
            #1;
            check({60'h0, gate}, {60'h0, ~hoe});
            s_hoe |= hoe;
            s_uoe |= uoe;
            s_doe |= doe;
            s_dl |= dl;
            s_fso |= fso;
            s_fsoe |= fsoe;
            s_dcoe |= dcoe;
            if (hwr && hslot == 5'h09)
                got_dn = hdn;
            if (swr)
                got_up = sup;
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #1;
        rstn_i = 1'b0;
        @(posedge clk_i);
        #1;
        check({60'h0, gate}, 64'hf);
        @(posedge clk_i);
        #1;
        check({60'h0, gate}, 64'hf);
        rstn_i = 1'b1;
        // iom, everything enabled
        run(400);
        run(2600);
        check({56'h0, tbyte}, 64'ha5);
        check({60'h0, s_hoe}, 64'hf);
        check({32'h0, got_dn}, 64'he9a96929);
        check(got_up, 64'hffffffff_00000000);
        check({52'h0, s_dl, s_uoe, s_doe}, 64'h00f);
        check({62'h0, s_fsoe, s_dcoe}, 64'h3);
        // open drain with ones, all slots flagged
        od = 1'b1;
        sdn = '1;
        flg = 4'hf;
        run(400);
        run(1300);
        check({52'h0, s_dl, s_hoe, s_doe}, 64'hf00);
        // burst mode, highway disabled
        bm = 1'b1;
        upl = 4'h5;
        asg = 8'h5a;
        od = 1'b0;
        sdn = '0;
        flg = 4'h0;
        hen = 1'b0;
        run(400);
        run(1300);
        check({56'h0, s_uoe, s_doe}, 64'h5a);
        check(got_up, 64'h00ff00ff_00000000);
        check({58'h0, s_hoe, s_fso, s_dcoe}, 64'h3);
        // iom slave framing, subscriber disabled
        bm = 1'b0;
        fm = 1'b0;
        cm = 1'b0;
        sen = 1'b0;
        run(400);
        run(1300);
        check({54'h0, s_fsoe, s_dcoe, s_uoe, s_doe}, 64'h0);
        wrap_up();
    end
endmodule
